// *** rtl/ofcm_det_if.sv ***
`timescale 1ns/1ps
interface ofcm_det_if #(
    parameter int SW = ofcm_pkg::SAMPLE_W,
    parameter int PW = ofcm_pkg::PULSE_W
);
    logic [SW-1:0] sample;
    logic [SW-1:0] threshold;
    logic [PW-1:0] minPulse;
    logic          flag;

    modport detector (input sample, input threshold, input minPulse, output flag);
    modport owner    (output sample, output threshold, output minPulse, input flag);
endinterface : ofcm_det_if

// *** rtl/ofcm_flag_clock_mux.sv ***
`timescale 1ns/1ps
module ofcm_flag_clock_mux #(
    parameter ofcm_pkg::ofcm_variant_t VARIANT = ofcm_pkg::VAR_QUAD,
    parameter int                      SW      = ofcm_pkg::SAMPLE_W,
    parameter int                      PW      = ofcm_pkg::PULSE_W
) (
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    // channel samples (magnitude)
    input  wire logic [SW-1:0] sampleA,
    input  wire logic [SW-1:0] sampleB,
    input  wire logic [SW-1:0] sampleC,
    // detection settings
    input  wire logic [SW-1:0] over_range_threshold,
    input  wire logic [PW-1:0] over_range_min_pulse,
    // clock-out control
    input  wire logic [1:0]    clock_out_select_pins,
    input  wire logic          serialClkOverride,
    input  wire logic [1:0]    serialClkSelect,
    input  wire logic          synthEnablePin,
    input  wire logic          power_down_pin,
    // outputs
    output logic               overrange_flag_a,
    output logic               overrange_flag_b,
    output logic               overrange_or_clock_c,
    output logic               synth_reference_output,
    output logic               clockModeC
);
    // ========================================
    // per-channel detectors
    logic [SW-1:0] sampleVec [ofcm_pkg::NUM_CH];
    logic [ofcm_pkg::NUM_CH-1:0] flagVec;

    assign sampleVec[0] = sampleA;
    assign sampleVec[1] = sampleB;
    assign sampleVec[2] = sampleC;

    genvar ch;
    generate
        for (ch = 0; ch < ofcm_pkg::NUM_CH; ch++) begin : g_ch
            ofcm_det_if #(.SW(SW), .PW(PW)) detLink ();

            assign detLink.sample    = sampleVec[ch];
            assign detLink.threshold = over_range_threshold;
            assign detLink.minPulse  = over_range_min_pulse;
            assign flagVec[ch]       = detLink.flag;

            ofcm_range_detector #(.PW(PW)) u_det (
                .ref_clk (ref_clk),
                .rst_n   (rst_n),
                .det     (detLink.detector)
            );
        end
    endgenerate

    // ========================================
    // variant gating
    localparam bit HAS_B = (VARIANT != ofcm_pkg::VAR_SINGLE);
    localparam bit HAS_C = (VARIANT == ofcm_pkg::VAR_QUAD);

    logic flagBGated;
    logic flagCGated;

    assign flagBGated = HAS_B ? flagVec[1] : 1'b0;
    assign flagCGated = HAS_C ? flagVec[2] : 1'b0;

    // ========================================
    // clock selection and divider
    localparam int DW = ofcm_pkg::DIV_W;

    typedef struct packed {
        logic [ofcm_pkg::DIV_W-1:0] div;
        logic                       refOut;
        logic                       outC;
        logic                       clkMode;
        logic                       flagA;
        logic                       flagB;
    } ofcm_top_state_t;

    ofcm_top_state_t st_r;
    ofcm_top_state_t st_nxt;
    logic [1:0]      effSel;
    logic            clkWanted;
    logic            clkRun;
    logic            clkC;

    // serial settings override the pins; pins alone act from reset
    assign effSel    = serialClkOverride ? serialClkSelect : clock_out_select_pins;
    assign clkWanted = (effSel != ofcm_pkg::SEL_FLAG) && synthEnablePin;
    assign clkRun    = synthEnablePin && !power_down_pin;

    always_comb begin
        st_nxt = st_r;
        // the reference itself is ref_clk/2 so every tap comes from a flop
        if (clkRun) begin
            st_nxt.div = DW'(st_r.div + DW'(1));
        end else begin
            st_nxt.div = ofcm_pkg::DIV_RST;
        end
        st_nxt.refOut = clkRun & st_nxt.div[ofcm_pkg::TAP_REF];
        case (effSel)
            ofcm_pkg::SEL_COPY: clkC = st_nxt.div[ofcm_pkg::TAP_REF];
            ofcm_pkg::SEL_DIV2: clkC = st_nxt.div[ofcm_pkg::TAP_DIV2];
            ofcm_pkg::SEL_DIV4: clkC = st_nxt.div[ofcm_pkg::TAP_DIV4];
            default:            clkC = 1'b0;
        endcase
        st_nxt.clkMode = clkWanted;
        if (clkWanted) begin
            // a stopped clock parks low rather than falling back to the flag
            st_nxt.outC = clkRun & clkC;
        end else begin
            st_nxt.outC = flagCGated;
        end
        st_nxt.flagA = flagVec[0];
        st_nxt.flagB = flagBGated;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r.div     <= ofcm_pkg::DIV_RST;
            st_r.refOut  <= 1'b0;
            st_r.outC    <= 1'b0;
            st_r.clkMode <= 1'b0;
            st_r.flagA   <= 1'b0;
            st_r.flagB   <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign overrange_flag_a       = st_r.flagA;
    assign overrange_flag_b       = st_r.flagB;
    assign overrange_or_clock_c   = st_r.outC;
    assign synth_reference_output = st_r.refOut;
    assign clockModeC             = st_r.clkMode;
endmodule : ofcm_flag_clock_mux

// *** rtl/ofcm_pkg.sv ***
package ofcm_pkg;
    // ========================================
    // widths and device variants
    localparam int SAMPLE_W   = 9;
    localparam int PULSE_W    = 8;
    localparam int DIV_W      = 3;
    localparam int NUM_CH     = 3;

    typedef enum logic [1:0] {
        VAR_SINGLE = 2'b00,
        VAR_DUAL   = 2'b01,
        VAR_QUAD   = 2'b10
    } ofcm_variant_t;

    // ========================================
    // clock-out selection codes
    localparam logic [1:0] SEL_FLAG   = 2'h0;
    localparam logic [1:0] SEL_COPY   = 2'h1;
    localparam logic [1:0] SEL_DIV2   = 2'h2;
    localparam logic [1:0] SEL_DIV4   = 2'h3;

    // ========================================
    // divider tap positions and reset values
    localparam int         TAP_REF    = 0;
    localparam int         TAP_DIV2   = 1;
    localparam int         TAP_DIV4   = 2;
    localparam logic [DIV_W-1:0]   DIV_RST   = 3'h0;
    localparam logic [PULSE_W-1:0] CNT_RST   = 8'h00;
    localparam logic [PULSE_W-1:0] CNT_ONE   = 8'h01;
endpackage : ofcm_pkg

// *** rtl/ofcm_range_detector.sv ***
`timescale 1ns/1ps
module ofcm_range_detector #(
    parameter int PW = ofcm_pkg::PULSE_W
) (
    // clock and reset
    input  wire logic    ref_clk,
    input  wire logic    rst_n,
    // detector link
    ofcm_det_if.detector det
);
    typedef struct packed {
        logic          flag;
        logic [PW-1:0] remain;
    } ofcm_det_state_t;

    ofcm_det_state_t st_r;
    ofcm_det_state_t st_nxt;
    logic            exceed;
    logic [PW-1:0]   holdLen;

    assign exceed  = det.sample > det.threshold;
    // a zero setting still yields a one-cycle pulse
    assign holdLen = (det.minPulse == '0) ? PW'(ofcm_pkg::CNT_ONE) : det.minPulse;

    always_comb begin
        st_nxt = st_r;
        if (exceed) begin
            st_nxt.flag   = 1'b1;
            st_nxt.remain = PW'(holdLen - PW'(1));
        end else if (st_r.remain != '0) begin
            st_nxt.remain = PW'(st_r.remain - PW'(1));
        end else begin
            st_nxt.flag   = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r.flag   <= 1'b0;
            st_r.remain <= PW'(ofcm_pkg::CNT_RST);
        end else begin
            st_r <= st_nxt;
        end
    end

    assign det.flag = st_r.flag;
endmodule : ofcm_range_detector

// *** testbench/ofcm_checker.sv ***
`timescale 1ns/1ps
module ofcm_checker #(
    parameter int SW = ofcm_pkg::SAMPLE_W,
    parameter int PW = ofcm_pkg::PULSE_W
) (
    // clock and reset
    input wire logic          ref_clk,
    input wire logic          rst_n,
    // inputs
    input wire logic [SW-1:0] sampleA,
    input wire logic [SW-1:0] sampleB,
    input wire logic [SW-1:0] sampleC,
    input wire logic [SW-1:0] over_range_threshold,
    input wire logic [PW-1:0] over_range_min_pulse,
    input wire logic [1:0]    clock_out_select_pins,
    input wire logic          serialClkOverride,
    input wire logic [1:0]    serialClkSelect,
    input wire logic          synthEnablePin,
    input wire logic          power_down_pin,
    // outputs
    input wire logic          overrange_flag_a,
    input wire logic          overrange_flag_b,
    input wire logic          overrange_or_clock_c,
    input wire logic          synth_reference_output,
    input wire logic          clockModeC
);
    // ========================================
    // properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire logic [SW-1:0] thr = over_range_threshold;
    wire logic [1:0]    sel = serialClkOverride ? serialClkSelect : clock_out_select_pins;
    wire logic          on  = synthEnablePin && !power_down_pin;
    property p_a; sampleA > thr |-> ##2 overrange_flag_a; endproperty
    a_a: assert property (p_a) else $error("flag a late");
    property p_b; sampleB > thr |-> ##2 overrange_flag_b; endproperty
    a_b: assert property (p_b) else $error("flag b late");
    property p_h; over_range_min_pulse == 8'h03 && $rose(overrange_flag_a) |-> overrange_flag_a[*3]; endproperty
    a_h: assert property (p_h) else $error("flag a short");
    property p_f; $fell(overrange_flag_a) |-> $past(sampleA, 2) <= $past(thr, 2); endproperty
    a_f: assert property (p_f) else $error("flag a early drop");
    property p_c; sampleC > thr && sel == 2'h0 ##1 sel == 2'h0 |-> ##1 overrange_or_clock_c; endproperty
    a_c: assert property (p_c) else $error("flag c late");
    property p_m; clockModeC == ($past(sel) != 2'h0 && $past(synthEnablePin)); endproperty
    a_m: assert property (p_m) else $error("clock mode wrong");
    property p_d; (sel == 2'h3 && on)[*8] |-> overrange_or_clock_c != $past(overrange_or_clock_c, 4); endproperty
    a_d: assert property (p_d) else $error("div4 wrong");
    property p_p; power_down_pin[*2] |-> !synth_reference_output && !(clockModeC && overrange_or_clock_c); endproperty
    a_p: assert property (p_p) else $error("clock runs in power-down");
    property p_r; on[*4] |-> synth_reference_output != $past(synth_reference_output); endproperty
    a_r: assert property (p_r) else $error("reference stalled");
endmodule : ofcm_checker
bind ofcm_flag_clock_mux ofcm_checker #(.SW(SW), .PW(PW)) i_chk (.*);

// *** testbench/ofcm_partner.sv ***
`timescale 1ns/1ps
// system side: counts clock edges arriving on channel C
module ofcm_partner (
    // watched lines
    input  wire logic clk,
    input  wire logic outC,
    // observation
    output int        risesC
);
    // idle level of the line is low, so no false edge after reset
    logic last  = 1'b0;
    int   count = 0;

    assign risesC = count;

    always @(posedge clk) begin
        last <= outC;
        if (outC && !last) count <= count + 1;
    end
endmodule : ofcm_partner

// *** testbench/tb_overrange_flag_clock_out_mux.sv ***
`timescale 1ns/1ps
module tb_overrange_flag_clock_out_mux;
    // ========================================
    // stimulus and observation
    logic [8:0] thr = 9'h100;
    logic [7:0] minPulse = 8'h03;
    logic       ref_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [8:0] sA = 9'h000, sB = 9'h000, sC = 9'h000;
    logic [1:0] pins = 2'h0, ssel = 2'h0;
    logic       ovr = 1'b0, synth = 1'b1, pd = 1'b0;
    logic       fA, fB, oC, refO, modeC;
    int         rises, err_total = 0, checked = 0, cycles = 0;
    initial forever #10 ref_clk = ~ref_clk;
    ofcm_flag_clock_mux i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .sampleA(sA), .sampleB(sB), .sampleC(sC),
        .over_range_threshold(thr), .over_range_min_pulse(minPulse),
        .clock_out_select_pins(pins), .serialClkOverride(ovr), .serialClkSelect(ssel),
        .synthEnablePin(synth), .power_down_pin(pd), .overrange_flag_a(fA),
        .overrange_flag_b(fB), .overrange_or_clock_c(oC), .synth_reference_output(refO),
        .clockModeC(modeC));
    ofcm_partner i_far (.clk(ref_clk), .outC(oC), .risesC(rises));
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        if (err_total == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    // one-cycle sample on the masked channels, then the flags until one cycle past the hold
    task automatic pulse(input logic [2:0] m, input logic [8:0] v);
        int hold;
        // a zero minimum-pulse setting still gives a one-cycle flag
        hold = (minPulse == 8'h00) ? 1 : int'(minPulse);
        {sA, sB, sC} = {m[2] ? v : 9'h000, m[1] ? v : 9'h000, m[0] ? v : 9'h000};
        cyc(1);
        {sA, sB, sC} = '0;
        for (int i = 0; i <= hold; i++) begin
            cyc(1);
            chk({fA, fB, oC}, (i < hold && v > thr) ? m : 3'h0);
        end
    endtask : pulse
    // settle first so divider phase after a switch does not skew the edge count
    task automatic mode(input logic [4:0] c, input logic md, input int exp);
        int r0;
        {pins, ovr, ssel} = c;
        cyc(12);
        r0 = rises;
        cyc(32);
        chk(rises - r0, exp);
        chk(modeC, md);
    endtask : mode
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        cyc(16);
        rst_n = 1'b1;
        cyc(2);
        pulse(3'h4, thr + 9'h001);
        pulse(3'h2, thr + 9'h001);
        pulse(3'h1, thr + 9'h001);
        pulse(3'h7, thr);
        minPulse = 8'h05;
        pulse(3'h4, thr + 9'h001);
        minPulse = 8'h00;
        pulse(3'h2, thr + 9'h001);
        minPulse = 8'h03;
        thr = 9'h020;
        pulse(3'h7, 9'h021);
        thr = 9'h100;
        mode(5'b01000, 1'b1, 16);
        mode(5'b10000, 1'b1, 8);
        mode(5'b11000, 1'b1, 4);
        mode(5'b00110, 1'b1, 8);
        mode(5'b11100, 1'b0, 0);
        pulse(3'h1, thr + 9'h001);
        synth = 1'b0;
        mode(5'b01000, 1'b0, 0);
        synth = 1'b1;
        pd = 1'b1;
        mode(5'b01000, 1'b1, 0);
        chk(refO, 1'b0);
        tally_and_finish();
    end
endmodule : tb_overrange_flag_clock_out_mux
